/* cdm_asserts.sv */
// Concurrent checks of the device end as seen on the link
`timescale 1ns/1ps
module cdm_asserts (
  input wire logic link_clk,
  input wire logic select,
  input wire logic chip_reset_in_n,
  input wire logic cmd_toggle,
  input wire logic [2:0] cmd_code,
  input wire logic [4:0] cmd_arg,
  input wire logic irq,
  input wire logic [2:0] fault,
  input wire logic [2:0] mode
);
  // ----------------------------------------------------------------
  // Mode sequencing, all in the link clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!chip_reset_in_n);

  property p_reset_pdown;
    $rose(chip_reset_in_n) |-> mode == cdm_pkg::CDM_PDOWN;
  endproperty
  a_reset_pdown: assert property (p_reset_pdown) else $error("mode not off after reset");
  property p_stay_down;
    (!select)[*4] ##0 mode == cdm_pkg::CDM_PDOWN |=> mode == cdm_pkg::CDM_PDOWN;
  endproperty
  a_stay_down: assert property (p_stay_down) else $error("woke without select");
  property p_wake;
    $rose(select) && mode == cdm_pkg::CDM_PDOWN |-> ##[1:8] mode == cdm_pkg::CDM_IDLE;
  endproperty
  a_wake: assert property (p_wake) else $error("select did not wake to idle");
  property p_start;
    $changed(cmd_toggle) && cmd_code == cdm_pkg::CMD_START_TX && mode == cdm_pkg::CDM_IDLE
      |-> ##[1:8] mode == cdm_pkg::CDM_OPER;
  endproperty
  a_start: assert property (p_start) else $error("start did not operate");
  property p_stop;
    $changed(cmd_toggle) && cmd_code == cdm_pkg::CMD_STOP_TX && mode == cdm_pkg::CDM_OPER
      |-> ##[1:8] mode == cdm_pkg::CDM_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not return to idle");
  property p_refuse;
    $changed(cmd_toggle) && cmd_code == cdm_pkg::CMD_START_TX && mode == cdm_pkg::CDM_SHUT
      |=> (mode == cdm_pkg::CDM_SHUT)[*8];
  endproperty
  a_refuse: assert property (p_refuse) else $error("start left shutdown");
  property p_shut_flag;
    $changed(mode) && mode == cdm_pkg::CDM_SHUT |-> ##[0:2] (irq && fault != 3'h0);
  endproperty
  a_shut_flag: assert property (p_shut_flag) else $error("shutdown without cause");
  property p_clear;
    $changed(cmd_toggle) && cmd_code == cdm_pkg::CMD_CLEAR_FAULT
      && (mode == cdm_pkg::CDM_SHUT || mode == cdm_pkg::CDM_DIAG)
      |-> ##[1:8] (mode != cdm_pkg::CDM_SHUT && mode != cdm_pkg::CDM_DIAG && fault == 3'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not resume");
  property p_diag;
    $changed(cmd_toggle) && cmd_code == cdm_pkg::CMD_DIAG && mode == cdm_pkg::CDM_IDLE
      |-> ##[1:8] mode == cdm_pkg::CDM_DIAG;
  endproperty
  a_diag: assert property (p_diag) else $error("diagnosis not entered");
  property p_select_keeps;
    $changed(cmd_toggle) && cmd_code == cdm_pkg::CMD_SELECT && cmd_arg >= cdm_pkg::NUM_COILS
      && mode == cdm_pkg::CDM_IDLE |=> (mode == cdm_pkg::CDM_IDLE)[*8];
  endproperty
  a_select_keeps: assert property (p_select_keeps) else $error("select moved mode");
endmodule

/* cdm_device.sv */
// Coil driver device end: mode sequencing, line states, boost gating
// ----------------------------------------------------------------
// Summary of operation
// (RQ1) Power-up: power-down, everything inactive
// (RQ2) Reset pulse forces power-down
// (RQ3) Select high wakes into idle
// (RQ4) Idle: selected pos half, return low
// (RQ5) Coil commands: operating mode, drivers active
// (RQ6) Line short: shutdown, stages off
// (RQ7) Clear-fault or reset leaves shutdown
// (RQ8) Diagnosis: drivers off, test sources on
// (RQ9) Command or reset exits diagnosis
// (RQ10) Non-selected coils both lines high
// (RQ11) Boost enabled only while transmitting
// (RQ12) Overcurrent or overvoltage stops boost switching
// (RQ13) Boost clock is oscillator divided 64
// (RQ14) Sine frequency from same oscillator
// (RQ15) Coil current set by host command
// (RQ16) Host keeps device powered down idle
// (RQ17) Fault records cause, raises interrupt
// (RQ18) Clear-fault clears register, resumes operation
// (RQ19) Host ends diagnosis with clear-fault
// (RQ20) Chip reset overrides every transition
// ----------------------------------------------------------------
`timescale 1ns/1ps
module cdm_device #(
  parameter int NUM_COILS = cdm_pkg::NUM_COILS
) (
  cdm_link_if.device LINK,
  input wire logic [NUM_COILS-1:0] SHORT_DETECT_IN,
  input wire logic [NUM_COILS-1:0] OPEN_DETECT_IN,
  input wire logic OVERTEMP_IN,
  input wire logic PEAK_CURRENT_HIGH_IN,
  input wire logic OUTPUT_VOLTAGE_HIGH_IN,
  output logic [3*NUM_COILS-1:0] COIL_POS_LINE_OUT,
  output logic [3*NUM_COILS-1:0] COIL_RETURN_LINE_OUT,
  output logic [NUM_COILS-1:0] TEST_SRC_HIGH_OUT,
  output logic BOOST_ENABLE_OUT,
  output logic BOOST_SWITCH_OUT,
  output logic SINE_CLK_OUT,
  output logic [4:0] CURRENT_SEL_OUT,
  output logic OSC_RUN_OUT
);

  // ----------------------------------------------------------------
  // Input synchronisers (pins from outside the link domain)
  // ----------------------------------------------------------------
  // Reset asserts at once but releases on the link clock, so no flop sees
  // its release and a clock edge in the same instant
  logic [1:0] rst_sync;
  always_ff @(posedge LINK.link_clk or negedge LINK.chip_reset_in_n) begin
    if (!LINK.chip_reset_in_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  logic rst_n;
  assign rst_n = rst_sync[1];  // see (RQ2) see (RQ20)

  logic [2:0] tog_s;
  logic [1:0] sel_s;
  logic [NUM_COILS-1:0] sh_s1, sh_s2, op_s1, op_s2;
  logic [1:0] ot_s, pk_s, ov_s;
  always_ff @(posedge LINK.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s <= 3'h0;
      sel_s <= 2'h0;
      sh_s1 <= '0;
      sh_s2 <= '0;
      op_s1 <= '0;
      op_s2 <= '0;
      ot_s <= 2'h0;
      pk_s <= 2'h0;
      ov_s <= 2'h0;
    end else begin
      tog_s <= {tog_s[1:0], LINK.cmd_toggle};
      sel_s <= {sel_s[0], LINK.select};
      sh_s1 <= SHORT_DETECT_IN;
      sh_s2 <= sh_s1;
      op_s1 <= OPEN_DETECT_IN;
      op_s2 <= op_s1;
      ot_s <= {ot_s[0], OVERTEMP_IN};
      pk_s <= {pk_s[0], PEAK_CURRENT_HIGH_IN};
      ov_s <= {ov_s[0], OUTPUT_VOLTAGE_HIGH_IN};
    end
  end

  // Command data is stable once the toggle is seen two stages later
  logic cmd_stb;
  assign cmd_stb = tog_s[2] ^ tog_s[1];

  logic is_start, is_stop, is_diag, is_clear, is_select, is_current;
  assign is_start = cmd_stb && (LINK.cmd_code == cdm_pkg::CMD_START_TX);
  assign is_stop = cmd_stb && (LINK.cmd_code == cdm_pkg::CMD_STOP_TX);
  assign is_diag = cmd_stb && (LINK.cmd_code == cdm_pkg::CMD_DIAG);
  assign is_clear = cmd_stb && (LINK.cmd_code == cdm_pkg::CMD_CLEAR_FAULT);
  assign is_select = cmd_stb && (LINK.cmd_code == cdm_pkg::CMD_SELECT);
  assign is_current = cmd_stb && (LINK.cmd_code == cdm_pkg::CMD_SET_CURRENT);

  logic [cdm_pkg::FAULT_W-1:0] fault_now;
  assign fault_now = {ot_s[1], |op_s2, |sh_s2};

  // ----------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------
  cdm_pkg::cdm_mode_t mode;
  always_ff @(posedge LINK.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= cdm_pkg::CDM_PDOWN;  // see (RQ1) see (RQ20)
    end else begin
      case (mode)
        cdm_pkg::CDM_PDOWN: begin
          if (sel_s[1]) begin
            mode <= cdm_pkg::CDM_IDLE;  // see (RQ3)
          end
        end
        cdm_pkg::CDM_IDLE: begin
          if (|fault_now) begin
            mode <= cdm_pkg::CDM_SHUT;  // see (RQ6)
          end else if (is_start) begin
            mode <= cdm_pkg::CDM_OPER;  // see (RQ5)
          end else if (is_diag) begin
            mode <= cdm_pkg::CDM_DIAG;  // see (RQ8)
          end
        end
        cdm_pkg::CDM_OPER: begin
          if (|fault_now) begin
            mode <= cdm_pkg::CDM_SHUT;  // see (RQ6)
          end else if (is_stop) begin
            mode <= cdm_pkg::CDM_IDLE;
          end
        end
        cdm_pkg::CDM_SHUT: begin
          // Transmission commands are ignored until the fault is cleared
          if (is_clear) begin
            mode <= cdm_pkg::CDM_IDLE;  // see (RQ7) see (RQ18)
          end
        end
        cdm_pkg::CDM_DIAG: begin
          if (is_clear) begin
            mode <= cdm_pkg::CDM_IDLE;  // see (RQ9) see (RQ19)
          end
        end
        default: mode <= cdm_pkg::CDM_PDOWN;
      endcase
    end
  end

  // Fault register: in idle or operating mode a new cause wins over a clear in the same cycle
  logic [cdm_pkg::FAULT_W-1:0] fault;
  logic irq;
  logic fault_live;
  assign fault_live = (mode == cdm_pkg::CDM_IDLE) || (mode == cdm_pkg::CDM_OPER);
  always_ff @(posedge LINK.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault <= '0;
      irq <= 1'b0;
    end else if (fault_live && |fault_now) begin
      fault <= fault | fault_now;  // see (RQ17)
      irq <= 1'b1;
    end else if (is_clear) begin
      fault <= '0;  // see (RQ18)
      irq <= 1'b0;
    end
  end
  assign LINK.irq = irq;
  assign LINK.fault = fault;
  assign LINK.mode = mode;

  // Selected coil, current step, diagnosis test-source settings
  logic [cdm_pkg::COIL_IDX_W-1:0] sel_coil;
  logic [4:0] cur_sel;
  logic [NUM_COILS-1:0] test_high;
  always_ff @(posedge LINK.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_coil <= '0;
      cur_sel <= 5'h00;
      test_high <= '0;
    end else if (mode != cdm_pkg::CDM_PDOWN) begin
      // The toggle synchroniser can show a false edge after reset: drop it while off
      if (is_select && LINK.cmd_arg < NUM_COILS) begin
        sel_coil <= LINK.cmd_arg[cdm_pkg::COIL_IDX_W-1:0];
      end
      if (is_current && mode == cdm_pkg::CDM_DIAG) begin
        test_high[sel_coil] <= LINK.cmd_arg[0];  // see (RQ8)
      end else if (is_current) begin
        cur_sel <= LINK.cmd_arg;  // see (RQ15)
      end
    end
  end
  assign CURRENT_SEL_OUT = cur_sel;
  assign TEST_SRC_HIGH_OUT = test_high;
  assign OSC_RUN_OUT = (mode != cdm_pkg::CDM_PDOWN);  // see (RQ3)

  // ----------------------------------------------------------------
  // Line states per coil
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COILS; gi++) begin : g_coil
      always_ff @(posedge LINK.link_clk or negedge rst_n) begin
        if (!rst_n) begin
          COIL_POS_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_HIZ;  // see (RQ1)
          COIL_RETURN_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_HIZ;
        end else if (mode == cdm_pkg::CDM_IDLE || mode == cdm_pkg::CDM_OPER) begin
          if (gi == sel_coil) begin
            COIL_POS_LINE_OUT[3*gi +: 3] <= (mode == cdm_pkg::CDM_OPER) ?
              cdm_pkg::LINE_DRIVE : cdm_pkg::LINE_HALF;  // see (RQ4) see (RQ5)
            COIL_RETURN_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_LOW;  // see (RQ4)
          end else begin
            COIL_POS_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_HIGH;  // see (RQ10)
            COIL_RETURN_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_HIGH;  // see (RQ10)
          end
        end else if (mode == cdm_pkg::CDM_DIAG) begin
          COIL_POS_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_TEST;  // see (RQ8)
          COIL_RETURN_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_TEST;
        end else begin
          COIL_POS_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_HIZ;  // see (RQ6)
          COIL_RETURN_LINE_OUT[3*gi +: 3] <= cdm_pkg::LINE_HIZ;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Boost converter gating and clocks
  // ----------------------------------------------------------------
  logic [cdm_pkg::BOOST_DIV_W-1:0] div;
  always_ff @(posedge LINK.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
    end else if (mode != cdm_pkg::CDM_PDOWN) begin
      div <= div + 1'b1;  // see (RQ13) see (RQ14)
    end
  end

  logic transmit;
  assign transmit = (mode == cdm_pkg::CDM_OPER);
  always_ff @(posedge LINK.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      BOOST_ENABLE_OUT <= 1'b0;
      BOOST_SWITCH_OUT <= 1'b0;
      SINE_CLK_OUT <= 1'b0;
    end else begin
      BOOST_ENABLE_OUT <= transmit;  // see (RQ11)
      // Switch on for the first half of each 64-cycle period
      BOOST_SWITCH_OUT <= transmit && !pk_s[1] && !ov_s[1]
                          && !div[cdm_pkg::BOOST_DIV_W-1];  // see (RQ12) see (RQ13)
      SINE_CLK_OUT <= transmit && div[cdm_pkg::BOOST_DIV_W-1];  // see (RQ14)
    end
  end

endmodule

/* cdm_host.sv */
// Host end: issues commands, makes the link clock, pulses chip reset
`timescale 1ns/1ps
module cdm_host (
  cdm_link_if.host LINK,
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [2:0] CMD_CODE_IN,
  input wire logic [4:0] CMD_ARG_IN,
  input wire logic SELECT_IN,
  input wire logic CHIP_RESET_REQ_IN,
  output logic CMD_READY_OUT,
  output logic IRQ_OUT,
  output logic [2:0] FAULT_OUT,
  output logic [2:0] MODE_OUT
);

  // ----------------------------------------------------------------
  // Link clock: REF_CLK divided by two
  // ----------------------------------------------------------------
  logic lclk;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lclk <= 1'b0;
    end else begin
      lclk <= ~lclk;
    end
  end
  assign LINK.link_clk = lclk;

  // ----------------------------------------------------------------
  // Chip reset pulse of at least the minimum width
  // ----------------------------------------------------------------
  logic [3:0] rst_cnt;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_cnt <= 4'(cdm_pkg::RESET_PULSE_CYC);
    end else if (CHIP_RESET_REQ_IN) begin
      rst_cnt <= 4'(cdm_pkg::RESET_PULSE_CYC);  // see (RQ2) see (RQ7) see (RQ9)
    end else if (rst_cnt != 4'h0) begin
      rst_cnt <= rst_cnt - 4'h1;
    end
  end
  // Registered, so the device's asynchronous reset never sees a decode glitch
  logic chip_rst_n;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      chip_rst_n <= 1'b0;
    end else begin
      chip_rst_n <= (rst_cnt == 4'h0) && !CHIP_RESET_REQ_IN;
    end
  end
  assign LINK.chip_reset_in_n = chip_rst_n;

  logic sel;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sel <= 1'b0;  // see (RQ16)
    end else begin
      sel <= SELECT_IN;
    end
  end
  assign LINK.select = sel;

  // ----------------------------------------------------------------
  // Command launch: toggle after data; hold off until seen by device
  // ----------------------------------------------------------------
  // Device needs about four link cycles to act; hold for 24 ref cycles
  logic tog;
  logic [2:0] code;
  logic [4:0] arg;
  logic [4:0] busy;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tog <= 1'b0;
      code <= 3'h0;
      arg <= 5'h00;
      busy <= 5'h00;
    end else if (busy != 5'h00) begin
      busy <= busy - 5'h01;
      if (busy == 5'h14) begin
        tog <= ~tog;
      end
    end else if (CMD_VALID_IN && CMD_READY_OUT) begin
      code <= CMD_CODE_IN;  // see (RQ19)
      arg <= CMD_ARG_IN;
      busy <= 5'h18;
    end
  end
  assign CMD_READY_OUT = (busy == 5'h00) && LINK.chip_reset_in_n;
  assign LINK.cmd_toggle = tog;
  assign LINK.cmd_code = code;
  assign LINK.cmd_arg = arg;

  logic [1:0] irq_s;
  logic [2:0] f1, f2, m1, m2;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_s <= 2'h0;
      f1 <= 3'h0;
      f2 <= 3'h0;
      m1 <= 3'h0;
      m2 <= 3'h0;
    end else begin
      irq_s <= {irq_s[0], LINK.irq};
      f1 <= LINK.fault;
      f2 <= f1;
      m1 <= LINK.mode;
      m2 <= m1;
    end
  end
  assign IRQ_OUT = irq_s[1];

  // Words from the link domain pass only once two samples agree, so a
  // multi-bit change caught halfway never reaches the outputs
  logic [2:0] f3, m3, fo, mo;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      f3 <= 3'h0;
      m3 <= 3'h0;
      fo <= 3'h0;
      mo <= 3'h0;
    end else begin
      f3 <= f2;
      m3 <= m2;
      if (f2 == f3) begin
        fo <= f2;
      end
      if (m2 == m3) begin
        mo <= m2;
      end
    end
  end
  assign FAULT_OUT = fo;
  assign MODE_OUT = mo;

endmodule

/* cdm_link_if.sv */
// Link between the host and the coil driver device
`timescale 1ns/1ps
interface cdm_link_if;
  logic link_clk;
  logic select;
  logic chip_reset_in_n;
  logic cmd_toggle;
  logic [2:0] cmd_code;
  logic [4:0] cmd_arg;
  logic irq;
  logic [2:0] fault;
  logic [2:0] mode;

  modport device (
    input link_clk, select, chip_reset_in_n, cmd_toggle, cmd_code, cmd_arg,
    output irq, fault, mode
  );
  modport host (
    output link_clk, select, chip_reset_in_n, cmd_toggle, cmd_code, cmd_arg,
    input irq, fault, mode
  );
endinterface

/* cdm_pkg.sv */
// Shared constants and types for the coil driver mode controller
package cdm_pkg;

  localparam int NUM_COILS = 6;
  localparam int COIL_IDX_W = 3;
  localparam int CUR_SEL_W = 5;

  // Host command codes (internal link encoding)
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_START_TX = 3'h1;
  localparam logic [2:0] CMD_STOP_TX = 3'h2;
  localparam logic [2:0] CMD_DIAG = 3'h3;
  localparam logic [2:0] CMD_CLEAR_FAULT = 3'h4;
  localparam logic [2:0] CMD_SELECT = 3'h5;
  localparam logic [2:0] CMD_SET_CURRENT = 3'h6;

  // Fault cause bits
  localparam int FAULT_W = 3;
  localparam logic [2:0] FAULT_SHORT = 3'h1;
  localparam logic [2:0] FAULT_OPEN = 3'h2;
  localparam logic [2:0] FAULT_TEMP = 3'h4;

  // Boost switching clock: 8 MHz oscillator divided to 125 kHz
  localparam int OSC_FREQ_KHZ = 8000;
  localparam int BOOST_FREQ_KHZ = 125;
  localparam int BOOST_DIV = OSC_FREQ_KHZ / BOOST_FREQ_KHZ;
  localparam int BOOST_DIV_W = 6;
  // Sine carrier divider from the same oscillator
  localparam int SINE_DIV = 64;

  // Minimum chip reset pulse, in host clock cycles (host clock 10 MHz)
  localparam int HOST_CLK_NS = 100;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + HOST_CLK_NS - 1) / HOST_CLK_NS;

  localparam logic [2:0] LINE_HIZ = 3'h0;
  localparam logic [2:0] LINE_HIGH = 3'h1;
  localparam logic [2:0] LINE_HALF = 3'h2;
  localparam logic [2:0] LINE_LOW = 3'h3;
  localparam logic [2:0] LINE_DRIVE = 3'h4;
  localparam logic [2:0] LINE_TEST = 3'h5;

  typedef enum logic [2:0] {
    CDM_PDOWN = 3'b000,
    CDM_IDLE = 3'b001,
    CDM_OPER = 3'b011,
    CDM_SHUT = 3'b010,
    CDM_DIAG = 3'b110
  } cdm_mode_t;

endpackage

/* coil_driver_mode_control_tb.sv */
// Self-checking bench joining the host and device ends over the link
`timescale 1ns/1ps
module coil_driver_mode_control_tb;
  localparam int NC = cdm_pkg::NUM_COILS;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic valid = 1'b0;
  logic [2:0] code = 3'h0;
  logic [4:0] arg = 5'h00;
  logic sel_in = 1'b0;
  logic rst_req = 1'b0;
  logic [NC-1:0] shorts = 6'h00;
  logic [NC-1:0] opens = 6'h00;
  logic hot = 1'b0;
  logic peak = 1'b0;
  logic over_v = 1'b0;
  logic ready, irq, sw, osc, boost, sine;
  logic [2:0] fault, mode;
  logic [3*NC-1:0] pos, ret;
  logic [NC-1:0] tsrc;
  logic [4:0] cur;
  logic [7:0] rnd = 8'h23;
  int fails = 0;
  int n_compared = 0;

  cdm_link_if lnk ();
  cdm_host u_cdm_host (.LINK(lnk), .REF_CLK_IN(ref_clk), .RESETN_IN(resetn),
    .CMD_VALID_IN(valid), .CMD_CODE_IN(code), .CMD_ARG_IN(arg), .SELECT_IN(sel_in),
    .CHIP_RESET_REQ_IN(rst_req), .CMD_READY_OUT(ready), .IRQ_OUT(irq), .FAULT_OUT(fault),
    .MODE_OUT(mode));
  cdm_device u_cdm_device (.LINK(lnk), .SHORT_DETECT_IN(shorts), .OPEN_DETECT_IN(opens),
    .OVERTEMP_IN(hot), .PEAK_CURRENT_HIGH_IN(peak), .OUTPUT_VOLTAGE_HIGH_IN(over_v),
    .COIL_POS_LINE_OUT(pos), .COIL_RETURN_LINE_OUT(ret), .TEST_SRC_HIGH_OUT(tsrc),
    .BOOST_ENABLE_OUT(boost), .BOOST_SWITCH_OUT(sw), .SINE_CLK_OUT(sine),
    .CURRENT_SEL_OUT(cur), .OSC_RUN_OUT(osc));
  cdm_asserts u_cdm_asserts (.link_clk(lnk.link_clk), .select(lnk.select),
    .chip_reset_in_n(lnk.chip_reset_in_n), .cmd_toggle(lnk.cmd_toggle),
    .cmd_code(lnk.cmd_code), .cmd_arg(lnk.cmd_arg), .irq(lnk.irq), .fault(lnk.fault),
    .mode(lnk.mode));

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [2:0] exp_line(input logic [2:0] m, input bit chosen, input bit p);
    case (m)
      cdm_pkg::CDM_IDLE: return !chosen ? cdm_pkg::LINE_HIGH : p ? cdm_pkg::LINE_HALF : cdm_pkg::LINE_LOW;
      cdm_pkg::CDM_OPER: return !chosen ? cdm_pkg::LINE_HIGH : p ? cdm_pkg::LINE_DRIVE : cdm_pkg::LINE_LOW;
      cdm_pkg::CDM_DIAG: return cdm_pkg::LINE_TEST;
      default: return cdm_pkg::LINE_HIZ;
    endcase
  endfunction

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Bounded, so a stuck handshake ends the run instead of hanging it
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1) begin
      tick(1);
      n++;
      if (n > 300) begin
        chk(8'h00, 8'h01);
        report_and_stop();
      end
    end
  endtask

  task automatic send(input logic [2:0] c, input logic [4:0] a);
    wait_ready();
    valid <= 1'b1;
    code <= c;
    arg <= a;
    tick(1);
    valid <= 1'b0;
    tick(2);
    wait_ready();
    tick(12);
  endtask

  task automatic check_mode(input logic [2:0] m, input int s);
    chk(mode, m);
    chk(boost, m == cdm_pkg::CDM_OPER);
    chk(osc, m != cdm_pkg::CDM_PDOWN);
    for (int i = 0; i < NC; i++) begin
      chk(pos[3*i +: 3], exp_line(m, i == s, 1'b1));
      chk(ret[3*i +: 3], exp_line(m, i == s, 1'b0));
    end
  endtask

  // Link cycles between two rising edges of the boost switch or sine clock, 0 if still
  task automatic rise_gap(input bit of_sine, output int gap);
    int n;
    logic last;
    logic v;
    n = 0;
    gap = 0;
    last = 1'b1;
    for (int k = 0; k < 400 && n < 2; k++) begin
      @(posedge lnk.link_clk);
      v = of_sine ? sine : sw;
      if (n == 1) gap++;
      if (v === 1'b1 && last === 1'b0) n++;
      last = v;
    end
    if (n < 2) gap = 0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int s;
    int g;
    logic [4:0] a;
    tick(16);
    resetn <= 1'b1;
    tick(40);
    chk(mode, cdm_pkg::CDM_PDOWN);
    sel_in <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      rnd = lfsr(rnd);
      s = rnd % NC;
      a = 5'(rnd % 20);
      send(cdm_pkg::CMD_SELECT, 5'(s));
      send(cdm_pkg::CMD_SELECT, {4'h3, rnd[0]});
      check_mode(cdm_pkg::CDM_IDLE, s);
      send(cdm_pkg::CMD_SET_CURRENT, a);
      chk(cur, a);
      send(cdm_pkg::CMD_START_TX, 5'h00);
      check_mode(cdm_pkg::CDM_OPER, s);
      shorts[s] <= (r == 0);
      opens[s] <= (r == 1);
      hot <= (r == 2);
      tick(40);
      chk(fault, 8'(1 << r));
      chk(irq, 1'b1);
      send(cdm_pkg::CMD_START_TX, 5'h00);
      check_mode(cdm_pkg::CDM_SHUT, s);
      shorts <= 6'h00;
      opens <= 6'h00;
      hot <= 1'b0;
      send(cdm_pkg::CMD_CLEAR_FAULT, 5'h00);
      chk(fault, 8'h00);
      chk(irq, 1'b0);
      send(cdm_pkg::CMD_STOP_TX, 5'h00);
      check_mode(cdm_pkg::CDM_IDLE, s);
    end
    rise_gap(1'b0, g);
    chk(8'(g), 8'h00);
    rise_gap(1'b1, g);
    chk(8'(g), 8'h00);
    send(cdm_pkg::CMD_START_TX, 5'h00);
    rise_gap(1'b0, g);
    chk(8'(g), 8'(cdm_pkg::BOOST_DIV));
    rise_gap(1'b1, g);
    chk(8'(g), 8'(cdm_pkg::SINE_DIV));
    for (int j = 0; j < 2; j++) begin
      {over_v, peak} <= (j == 0) ? 2'h1 : 2'h2;
      tick(10);
      rise_gap(1'b0, g);
      chk(8'(g), 8'h00);
    end
    {over_v, peak} <= 2'h0;
    send(cdm_pkg::CMD_STOP_TX, 5'h00);
    send(cdm_pkg::CMD_DIAG, 5'h00);
    check_mode(cdm_pkg::CDM_DIAG, s);
    send(cdm_pkg::CMD_SET_CURRENT, 5'h01);
    chk(tsrc[s], 1'b1);
    send(cdm_pkg::CMD_CLEAR_FAULT, 5'h00);
    check_mode(cdm_pkg::CDM_IDLE, s);
    send(cdm_pkg::CMD_START_TX, 5'h00);
    sel_in <= 1'b0;
    rst_req <= 1'b1;
    tick(1);
    rst_req <= 1'b0;
    tick(60);
    check_mode(cdm_pkg::CDM_PDOWN, s);
    report_and_stop();
  end
endmodule
